// >>> core/ssc_pkg.sv
// package: constants and types for the supply supervisor control block
package ssc_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   // start-up delays, in microseconds as given
   localparam int unsigned STARTUP_BO_US = 3300;
   localparam int unsigned STARTUP_NOBO_US = 1000;
   localparam int unsigned STARTUP_BO_CYC = STARTUP_BO_US * (CLK_HZ / 1_000_000);
   localparam int unsigned STARTUP_NOBO_CYC = STARTUP_NOBO_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 18;
   // brownout level select: five levels, 1.8 V up to 3 V
   localparam int unsigned BO_LVL_W = 3;
   localparam logic [2:0] BO_LVL_MAX = 3'h4;
   localparam logic [2:0] BO_LVL_DEF = 3'h0;
   // detector level select: seven levels, 1.85 V to 3.05 V, ~200 mV steps
   localparam int unsigned DET_LVL_W = 3;
   localparam logic [2:0] DET_LVL_MAX = 3'h6;
   localparam logic [2:0] DET_LVL_DEF = 3'h0;
   // edge select field positions
   localparam int unsigned EDGE_FALL_BIT = 0;
   localparam int unsigned EDGE_RISE_BIT = 1;
   localparam logic [1:0] EDGE_DEF = 2'h0;

   typedef enum logic [3:0] {
      SSC_OFF  = 4'h1,
      SSC_LOAD = 4'h2,
      SSC_WAIT = 4'h4,
      SSC_RUN  = 4'h8
   } ssc_state_t;
endpackage : ssc_pkg

// >>> core/ssc_sync.sv
// two-flop synchroniser for asynchronous comparator levels
`timescale 1ns/1ns
module ssc_sync #(
   parameter int unsigned W = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : ssc_sync

// >>> core/ssc_top.sv
// supply supervisor control: reset hold, option load, detector and stop gating
//
// Overview of operation
// - hold chip reset while the power-down indicator, or the brownout indicator when brownout is enabled, asserts
// - start option load once start threshold reached
// - variant input picks brownout-at-power-on behaviour
// - five brownout levels, driven from loaded options
// - gate internal reference off in stop if enabled
// - software selects seven detector levels
// - interrupt on falling, rising or both crossings
// - detector inactive until software enables it
// - start-up delay 3.3 ms or 1 ms by variant
`timescale 1ns/1ns
module ssc_top
   import ssc_pkg::*;
#(
   parameter int unsigned STARTUP_BO = STARTUP_BO_CYC,
   parameter int unsigned STARTUP_NOBO = STARTUP_NOBO_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic power_down_reset_ind,
   input wire logic brownout_reset_ind,
   input wire logic start_thr_ok,
   input wire logic detector_above,
   input wire logic bo_at_poweron,
   input wire logic opt_load_done,
   input wire logic [2:0] opt_bo_level,
   input wire logic opt_bo_disable,
   input wire logic stop_mode,
   input wire logic ref_stop_off_en,
   input wire logic det_enable,
   input wire logic [2:0] det_level_sel,
   input wire logic [1:0] det_edge_sel,
   input wire logic det_fall_clr,
   input wire logic det_rise_clr,
   output logic chip_reset_ff,
   output logic opt_load_start_ff,
   output logic [2:0] brownout_level_ff,
   output logic brownout_en_ff,
   output logic internal_reference_on_ff,
   output logic detector_en_ff,
   output logic [2:0] detector_level_ff,
   output logic det_fall_pend_ff,
   output logic det_rise_pend_ff,
   output logic det_irq_ff
);
   logic pwr_low_s, bo_low_s, start_s, above_s, above_d_ff;
   logic [1:0] edge_sel_ff;
   logic variant_ff;
   ssc_state_t state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic supply_low, fall_ev, rise_ev;

   ssc_sync #(.W(4)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_in({power_down_reset_ind, brownout_reset_ind, start_thr_ok, detector_above}),
      .sync_out({pwr_low_s, bo_low_s, start_s, above_s})
   );

   // brownout counts only while its detection is enabled
   assign supply_low = pwr_low_s | (bo_low_s & brownout_en_ff);

   function automatic logic [CNT_W-1:0] startup_len(input logic bo_on);
      startup_len = bo_on ? CNT_W'(STARTUP_BO - 1) : CNT_W'(STARTUP_NOBO - 1);
   endfunction : startup_len

   // strap caught by a clocked process, never by the reset itself
   always_ff @(posedge mclk) begin
      if (state_ff == SSC_OFF) begin
         variant_ff <= bo_at_poweron;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SSC_OFF: begin
            if (start_s && !pwr_low_s) begin
               nxt_state = SSC_LOAD;
            end
         end
         SSC_LOAD: begin
            if (supply_low) begin
               nxt_state = SSC_OFF;
            end else if (opt_load_done) begin
               nxt_state = SSC_WAIT;
            end
         end
         SSC_WAIT: begin
            if (supply_low) begin
               nxt_state = SSC_OFF;
            end else if (cnt_ff == '0) begin
               nxt_state = SSC_RUN;
            end
         end
         SSC_RUN: begin
            if (supply_low) begin
               nxt_state = SSC_OFF;
            end
         end
         default: nxt_state = SSC_OFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_ff <= SSC_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_ff <= '0;
      end else if (state_ff != SSC_WAIT) begin
         cnt_ff <= startup_len(variant_ff);
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         chip_reset_ff <= 1'b1;
         opt_load_start_ff <= 1'b0;
      end else begin
         chip_reset_ff <= (nxt_state != SSC_RUN);
         opt_load_start_ff <= (state_ff == SSC_OFF) && (nxt_state == SSC_LOAD);
      end
   end

   // brownout settings: variant default until options land, then option bytes
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         brownout_en_ff <= 1'b0;
         brownout_level_ff <= BO_LVL_DEF;
      end else if (state_ff == SSC_OFF) begin
         brownout_en_ff <= variant_ff;
         brownout_level_ff <= BO_LVL_DEF;
      end else if (state_ff == SSC_LOAD && opt_load_done) begin
         brownout_en_ff <= ~opt_bo_disable;
         // out-of-range codes clamp to the top level
         brownout_level_ff <= (opt_bo_level > BO_LVL_MAX) ? BO_LVL_MAX : opt_bo_level;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         internal_reference_on_ff <= 1'b1;
      end else begin
         internal_reference_on_ff <= !(stop_mode && ref_stop_off_en);
      end
   end

   // software controls are held at defaults while chip reset is out
   always_ff @(posedge mclk) begin
      if (!nrst || chip_reset_ff) begin
         detector_en_ff <= 1'b0;
         detector_level_ff <= DET_LVL_DEF;
         edge_sel_ff <= EDGE_DEF;
      end else begin
         detector_en_ff <= det_enable;
         detector_level_ff <= (det_level_sel > DET_LVL_MAX) ? DET_LVL_MAX : det_level_sel;
         edge_sel_ff <= det_edge_sel;
      end
   end

   // previous level resampled while disabled so enabling makes no false edge
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         above_d_ff <= 1'b0;
      end else begin
         above_d_ff <= above_s;
      end
   end

   // enable lags chip reset by one edge, so crossings are also gated by reset itself
   assign fall_ev = detector_en_ff & ~chip_reset_ff & edge_sel_ff[EDGE_FALL_BIT]
                    & above_d_ff & ~above_s;
   assign rise_ev = detector_en_ff & ~chip_reset_ff & edge_sel_ff[EDGE_RISE_BIT]
                    & ~above_d_ff & above_s;

   // set wins over a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!nrst || chip_reset_ff) begin
         det_fall_pend_ff <= 1'b0;
         det_rise_pend_ff <= 1'b0;
      end else begin
         det_fall_pend_ff <= fall_ev | (det_fall_pend_ff & ~det_fall_clr);
         det_rise_pend_ff <= rise_ev | (det_rise_pend_ff & ~det_rise_clr);
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst || chip_reset_ff) begin
         det_irq_ff <= 1'b0;
      end else begin
         det_irq_ff <= fall_ev | rise_ev
                       | (det_fall_pend_ff & ~det_fall_clr)
                       | (det_rise_pend_ff & ~det_rise_clr);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_low_holds_reset: assert property (supply_low |=> chip_reset_ff)
      else $error("reset not held while supply low");
   chk_load_pulse: assert property ($rose(opt_load_start_ff) |-> $past(state_ff) == SSC_OFF
      && state_ff == SSC_LOAD)
      else $error("option load start without leaving off state");
   chk_bo_level_range: assert property (brownout_level_ff <= BO_LVL_MAX)
      else $error("brownout level out of range");
   chk_ref_stop_gate: assert property (stop_mode && ref_stop_off_en
      |=> !internal_reference_on_ff)
      else $error("internal reference left on in stop");
   chk_det_level_range: assert property (detector_level_ff <= DET_LVL_MAX)
      else $error("detector level out of range");
   chk_fall_sets_pend: assert property (fall_ev |=> det_fall_pend_ff && det_irq_ff)
      else $error("falling crossing lost");
   chk_idle_no_irq: assert property (!detector_en_ff && !det_fall_pend_ff
      && !det_rise_pend_ff |=> !det_irq_ff)
      else $error("interrupt while detector disabled");
   chk_wait_length: assert property (state_ff == SSC_WAIT && cnt_ff == '0 && !supply_low
      |=> state_ff == SSC_RUN && !chip_reset_ff)
      else $error("start-up delay end not honoured");
   chk_pend_sticky: assert property (det_rise_pend_ff && !det_rise_clr && !chip_reset_ff
      |=> det_rise_pend_ff)
      else $error("pending flag dropped without clear");
   chk_reset_defaults: assert property (chip_reset_ff |=> !detector_en_ff
      && detector_level_ff == DET_LVL_DEF)
      else $error("detector controls not defaulted in reset");

   cov_release: cover property ($fell(chip_reset_ff));
   cov_bo_disable: cover property (state_ff == SSC_LOAD && opt_load_done && opt_bo_disable);
   cov_rise_irq: cover property (rise_ev);
   cov_brownout_reset: cover property (state_ff == SSC_RUN && bo_low_s && brownout_en_ff);
endmodule : ssc_top

// >>> dv/ssc_supply_model.sv
// far-side model: supply comparators and option loader driven by a supply level in mV
`timescale 1ns/1ns
module ssc_supply_model (
   input wire logic mclk,
   input wire logic [11:0] supply_mv,
   input wire logic bo_at_poweron,
   input wire logic [2:0] brownout_level_ff,
   input wire logic [2:0] detector_level_ff,
   input wire logic opt_load_start_ff,
   input wire logic [2:0] opt_level_cfg,
   input wire logic opt_dis_cfg,
   output logic power_down_reset_ind,
   output logic brownout_reset_ind,
   output logic start_thr_ok,
   output logic detector_above,
   output logic opt_load_done,
   output logic [2:0] opt_bo_level,
   output logic opt_bo_disable
);
   logic [2:0] load_cnt_ff = 3'h0;
   assign power_down_reset_ind = supply_mv < 12'd1600;
   assign start_thr_ok = supply_mv >= (bo_at_poweron ? 12'd1800 : 12'd1650);
   assign brownout_reset_ind = supply_mv < 12'd1800 + 12'd300 * brownout_level_ff;
   assign detector_above = supply_mv > 12'd1850 + 12'd200 * detector_level_ff;
   // option values are only valid with the done strobe; show garbage otherwise
   assign opt_bo_level = opt_load_done ? opt_level_cfg : ~opt_level_cfg;
   assign opt_bo_disable = opt_load_done ? opt_dis_cfg : ~opt_dis_cfg;
   always_ff @(posedge mclk) begin
      if (opt_load_start_ff) load_cnt_ff <= 3'h3;
      else if (load_cnt_ff != 3'h0) load_cnt_ff <= load_cnt_ff - 3'h1;
      opt_load_done <= load_cnt_ff == 3'h1;
   end
endmodule : ssc_supply_model

// >>> dv/ssc_top_tb_top.sv
// testbench: power-up, brownout, detector events and reference gating
`timescale 1ns/1ns
module ssc_top_tb_top;
   import ssc_pkg::*;
   localparam int unsigned T_BO = 20;
   localparam int unsigned T_NOBO = 8;
   // loader answers the start pulse four edges later, then one edge into the wait state
   localparam int unsigned LOAD_LAT = 5;
   logic mclk = 0, nrst = 0, bo_at_poweron = 1, stop_mode = 0, ref_stop_off_en = 0;
   logic det_enable = 0, det_fall_clr = 0, det_rise_clr = 0, opt_dis_cfg = 0;
   logic [11:0] supply_mv = 12'd0;
   logic [2:0] det_level_sel = 3'h7, opt_level_cfg = 3'h0;
   logic [1:0] det_edge_sel = 2'h0;
   logic pwr_low, bo_low, thr_ok, above, ld_done, ld_dis, chip_reset_ff, opt_load_start_ff;
   logic brownout_en_ff, internal_reference_on_ff, detector_en_ff;
   logic det_fall_pend_ff, det_rise_pend_ff, det_irq_ff;
   logic [2:0] ld_lvl, brownout_level_ff, detector_level_ff;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   ssc_top #(.STARTUP_BO(T_BO), .STARTUP_NOBO(T_NOBO)) ssc_top_inst (.mclk(mclk), .nrst(nrst),
      .power_down_reset_ind(pwr_low), .brownout_reset_ind(bo_low), .start_thr_ok(thr_ok),
      .detector_above(above), .bo_at_poweron(bo_at_poweron), .opt_load_done(ld_done),
      .opt_bo_level(ld_lvl), .opt_bo_disable(ld_dis), .stop_mode(stop_mode),
      .ref_stop_off_en(ref_stop_off_en), .det_enable(det_enable),
      .det_level_sel(det_level_sel), .det_edge_sel(det_edge_sel),
      .det_fall_clr(det_fall_clr), .det_rise_clr(det_rise_clr),
      .chip_reset_ff(chip_reset_ff), .opt_load_start_ff(opt_load_start_ff),
      .brownout_level_ff(brownout_level_ff), .brownout_en_ff(brownout_en_ff),
      .internal_reference_on_ff(internal_reference_on_ff), .detector_en_ff(detector_en_ff),
      .detector_level_ff(detector_level_ff), .det_fall_pend_ff(det_fall_pend_ff),
      .det_rise_pend_ff(det_rise_pend_ff), .det_irq_ff(det_irq_ff));
   ssc_supply_model ssc_supply_model_inst (.mclk(mclk), .supply_mv(supply_mv),
      .bo_at_poweron(bo_at_poweron), .brownout_level_ff(brownout_level_ff),
      .detector_level_ff(detector_level_ff), .opt_load_start_ff(opt_load_start_ff),
      .opt_level_cfg(opt_level_cfg), .opt_dis_cfg(opt_dis_cfg), .power_down_reset_ind(pwr_low),
      .brownout_reset_ind(bo_low), .start_thr_ok(thr_ok), .detector_above(above),
      .opt_load_done(ld_done), .opt_bo_level(ld_lvl), .opt_bo_disable(ld_dis));
   initial begin
      forever #10 mclk = ~mclk;
   end
   task automatic complete_run;
      if (n_mismatch == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   task automatic check1(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask : check1
   task automatic check3(input string what, input logic [2:0] exp, input logic [2:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check3
   task automatic cycles(input int n);
      repeat (n) @(negedge mclk);
   endtask : cycles
   // raise supply, serve option load, time the release from the load pulse
   task automatic power_up(input logic strap, input logic [2:0] lvl, input logic dis,
                           input int unsigned tmin);
      int n;
      bo_at_poweron = strap;
      opt_level_cfg = lvl;
      opt_dis_cfg = dis;
      supply_mv = 12'd3300;
      n = 0;
      while (opt_load_start_ff !== 1'b1 && n < 20) begin
         cycles(1);
         n++;
      end
      check1("load_start", 1'b1, opt_load_start_ff);
      n = 0;
      while (chip_reset_ff !== 1'b0 && n < 100) begin
         cycles(1);
         n++;
      end
      check1("startup_time", 1'b1, n == tmin + LOAD_LAT);
   endtask : power_up
   task automatic det_try(input logic en, input logic [1:0] edg, input logic [11:0] mv,
                          input logic expf, input logic expr);
      det_enable = en;
      det_edge_sel = edg;
      supply_mv = mv;
      cycles(6);
      check1("fall_pend", expf, det_fall_pend_ff);
      check1("rise_pend", expr, det_rise_pend_ff);
      check1("det_irq", expf | expr, det_irq_ff);
      det_fall_clr = 1;
      det_rise_clr = 1;
      cycles(1);
      det_fall_clr = 0;
      det_rise_clr = 0;
      cycles(2);
      check1("irq_cleared", 1'b0, det_irq_ff);
   endtask : det_try
   initial begin
      cycles(16);
      check1("rst_hold", 1'b1, chip_reset_ff);
      check1("ref_on", 1'b1, internal_reference_on_ff);
      nrst = 1;
      cycles(10);
      check1("low_supply_hold", 1'b1, chip_reset_ff);
      power_up(1'b1, 3'h5, 1'b0, T_BO);
      check3("bo_level_clamp", BO_LVL_MAX, brownout_level_ff);
      check1("bo_en", 1'b1, brownout_en_ff);
      supply_mv = 12'd2900;
      cycles(5);
      check1("brownout_reset", 1'b1, chip_reset_ff);
      supply_mv = 12'd1000;
      cycles(5);
      power_up(1'b0, 3'h2, 1'b1, T_NOBO);
      check1("bo_disabled", 1'b0, brownout_en_ff);
      check3("bo_level_opt", 3'h2, brownout_level_ff);
      // below the applied brownout level, so the disabled brownout is really exercised
      det_try(1'b0, 2'h3, 12'd2000, 1'b0, 1'b0);
      check1("bo_ignored", 1'b0, chip_reset_ff);
      det_try(1'b0, 2'h3, 12'd3300, 1'b0, 1'b0);
      det_try(1'b1, 2'h1, 12'd2900, 1'b1, 1'b0);
      check3("det_level_clamp", DET_LVL_MAX, detector_level_ff);
      det_try(1'b1, 2'h1, 12'd3300, 1'b0, 1'b0);
      det_try(1'b1, 2'h2, 12'd2900, 1'b0, 1'b0);
      det_try(1'b1, 2'h2, 12'd3300, 1'b0, 1'b1);
      det_try(1'b1, 2'h3, 12'd2900, 1'b1, 1'b0);
      det_try(1'b1, 2'h3, 12'd3300, 1'b0, 1'b1);
      det_level_sel = 3'h2;
      cycles(2);
      check3("det_level_sel", 3'h2, detector_level_ff);
      stop_mode = 1;
      cycles(2);
      check1("ref_kept", 1'b1, internal_reference_on_ff);
      ref_stop_off_en = 1;
      cycles(2);
      check1("ref_off_stop", 1'b0, internal_reference_on_ff);
      stop_mode = 0;
      cycles(2);
      check1("ref_back_on", 1'b1, internal_reference_on_ff);
      supply_mv = 12'd1500;
      cycles(5);
      check1("pwr_low_reset", 1'b1, chip_reset_ff);
      check1("det_en_default", 1'b0, detector_en_ff);
      check3("det_lvl_default", DET_LVL_DEF, detector_level_ff);
      complete_run();
   end
   // hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc >= 5000) begin
         n_mismatch++;
         complete_run();
      end
   end
endmodule : ssc_top_tb_top
